// ===== rtl/pfs_consts.vh
// Register map, field layout and reset values of the fault source selector
`ifndef PFS_CONSTS_VH
`define PFS_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
// Register byte addresses (full 32-bit bus address)
`define PFS_ADDR_FAULT_EN      32'h0013003c
`define PFS_ADDR_DIODE_EN      32'h00130040
`define PFS_ADDR_IRQ_STATUS    32'h00130080
`define PFS_ADDR_IRQ_MASK      32'h00130084
`define PFS_ADDR_LIVE_STATE    32'h00130088

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define PFS_RST_FAULT_EN       32'h00000000
`define PFS_RST_DIODE_EN       32'h00000000
`define PFS_RST_IRQ_MASK       32'h00000000

////////////////////////////////////////////////////////////////////////////////
// Writable bits of each register; bit 15 and bit 31 of the fault register stay zero
`define PFS_WMASK_FAULT_EN     32'h7fff7fff
`define PFS_WMASK_DIODE_EN     32'h0000007f
`define PFS_WMASK_IRQ_MASK     32'h00000007

////////////////////////////////////////////////////////////////////////////////
// Field positions in the fault source enable register
`define PFS_OUT_B_LSB          16
`define PFS_OUT_B_MSB          30
`define PFS_OUT_A_LSB          0
`define PFS_OUT_A_MSB          14
// Within each 15-bit group: digital 14:11, external 10:7, analog 6:0
`define PFS_GRP_DIG_LSB        11
`define PFS_GRP_EXT_LSB        7
`define PFS_GRP_ANA_LSB        0
`define PFS_GRP_W              15
// Diode emulation register: analog G..A at 6:0
`define PFS_DIODE_MSB          6
`define PFS_DIODE_LSB          0

////////////////////////////////////////////////////////////////////////////////
// Event bits of status, mask and live state registers
`define PFS_EV_OUT_A           0
`define PFS_EV_OUT_B           1
`define PFS_EV_DIODE           2
`define PFS_EV_W               3

////////////////////////////////////////////////////////////////////////////////
// AXI response codes
`define PFS_RESP_OKAY          2'h0
`define PFS_RESP_SLVERR        2'h2

`endif

// ===== rtl/pfs_sync2.v
// Two flip-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/100ps
module pfs_sync2 #(
	parameter WIDTH = 1
) (
	input  wire             aclk,
	input  wire             aresetn,
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta_r;   // First stage, read only by the second
	reg [WIDTH-1:0] sync_r;   // Second stage, safe to use

	////////////////////////////////////////////////////////////////////////////
	// Both stages clear on reset so nothing spurious leaves the block
	always @(posedge aclk) begin
		if (!aresetn) begin
			meta_r <= {WIDTH{1'b0}};
			sync_r <= {WIDTH{1'b0}};
		end else begin
			meta_r <= async_in;
			sync_r <= meta_r;
		end
	end

	assign sync_out = sync_r;

endmodule

// ===== rtl/pfs_top.v
// Fault and diode emulation source selection for the first pulse modulator channel
//
// Operation
// - Output B takes digital compares on bits 30:27
// - Output B takes external inputs on bits 26:23
// - Output B takes analog compares on bits 22:16
// - Output A takes digital compares on bits 14:11
// - Output A takes external inputs on bits 10:7
// - Output A takes analog compares on bits 6:0
// - Diode emulation takes analog compares, bits 6:0
// - All enables clear after reset
`timescale 1ns/100ps
`include "pfs_consts.vh"
module pfs_top (
	input  wire        aclk,
	input  wire        aresetn,
	// AXI4-Lite write address
	input  wire [31:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	// AXI4-Lite write response
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read address
	input  wire [31:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	// AXI4-Lite read data
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	// Fault sources
	input  wire [3:0]  digital_threshold_compare,
	input  wire [3:0]  ext_fault_in,
	input  wire [6:0]  analog_threshold_compare,
	// Detection results
	output wire        out_a_fault_detect,
	output wire        out_b_fault_detect,
	output wire        ideal_diode_emulation_detect,
	output wire        irq
);

	////////////////////////////////////////////////////////////////////////////
	// Helper functions

	// OR of all sources whose enable is set
	function any_enabled;
		input [`PFS_GRP_W-1:0] enables;
		input [`PFS_GRP_W-1:0] sources;
		begin
			any_enabled = |(enables & sources);
		end
	endfunction

	// Merge write data into a register under byte strobes and a writable mask
	function [31:0] strobe_merge;
		input [31:0] old_val;
		input [31:0] new_val;
		input [3:0]  strb;
		input [31:0] wmask;
		reg   [31:0] byte_en;
		begin
			byte_en      = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
			strobe_merge = ((old_val & ~byte_en) | (new_val & byte_en)) & wmask;
		end
	endfunction

	// Address is one of the mapped words
	function addr_mapped;
		input [31:0] addr;
		begin
			addr_mapped = (addr == `PFS_ADDR_FAULT_EN) ||
				(addr == `PFS_ADDR_DIODE_EN) ||
				(addr == `PFS_ADDR_IRQ_STATUS) ||
				(addr == `PFS_ADDR_IRQ_MASK) ||
				(addr == `PFS_ADDR_LIVE_STATE);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Declarations

	reg  [31:0] fault_en_r;        // Output A/B source enables
	reg  [31:0] diode_en_r;        // Diode emulation source enables
	reg  [31:0] irq_mask_r;        // Interrupt mask
	reg  [`PFS_EV_W-1:0] irq_status_r;  // Sticky event bits
	reg  [`PFS_EV_W-1:0] irq_status_nxt;

	reg         awready_r;         // Write address slot free
	reg         wready_r;          // Write data slot free
	reg         aw_full_r;         // Address held
	reg         w_full_r;          // Data held
	reg  [31:0] aw_addr_r;         // Held write address
	reg  [31:0] w_data_r;          // Held write data
	reg  [3:0]  w_strb_r;          // Held byte strobes
	reg         bvalid_r;          // Write response pending
	reg  [1:0]  bresp_r;           // Write response code

	reg         arready_r;         // Read address slot free
	reg         rvalid_r;          // Read data pending
	reg  [31:0] rdata_r;           // Read data
	reg  [1:0]  rresp_r;           // Read response code

	reg         fault_a_r;         // Registered output A detection
	reg         fault_b_r;         // Registered output B detection
	reg         diode_r;           // Registered diode emulation detection
	reg         irq_r;             // Registered interrupt level

	wire [3:0]  ext_sync;          // External pins after synchroniser
	wire [6:0]  ana_sync;          // Analog compares after synchroniser
	wire [`PFS_GRP_W-1:0] src_vec; // All sources in field order
	wire        fault_a_nxt;       // Combined output A detection
	wire        fault_b_nxt;       // Combined output B detection
	wire        diode_nxt;         // Combined diode emulation detection
	wire [`PFS_EV_W-1:0] ev_rise;  // Rising edges of detections
	wire        do_write;          // Both halves of a write are held
	wire        ar_take;           // Read address handshake
	wire [31:0] live_state;        // Current detection levels

	////////////////////////////////////////////////////////////////////////////
	// Input synchronisers
	// Pins and analog comparators come from outside the clock domain, so they
	// pay two cycles of latency; digital compares are on-chip and pass directly.

	pfs_sync2 #(
		.WIDTH (4)
	) u_ext_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in (ext_fault_in),
		.sync_out (ext_sync)
	);

	pfs_sync2 #(
		.WIDTH (7)
	) u_ana_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in (analog_threshold_compare),
		.sync_out (ana_sync)
	);

	////////////////////////////////////////////////////////////////////////////
	// Source selection
	// The 15-bit source vector matches the field order of both output groups,
	// so one AND-OR serves A and B alike.

	assign src_vec = {digital_threshold_compare, ext_sync, ana_sync};

	// Output B group, bits 30:16
	assign fault_b_nxt = any_enabled(fault_en_r[`PFS_OUT_B_MSB:`PFS_OUT_B_LSB],
		src_vec);

	// Output A group, bits 14:0
	assign fault_a_nxt = any_enabled(fault_en_r[`PFS_OUT_A_MSB:`PFS_OUT_A_LSB],
		src_vec);

	// Diode emulation: analog compares only, digital and external held off
	assign diode_nxt = any_enabled({8'h00, diode_en_r[`PFS_DIODE_MSB:`PFS_DIODE_LSB]},
		{8'h00, ana_sync});

	////////////////////////////////////////////////////////////////////////////
	// Registered detection outputs
	always @(posedge aclk) begin
		if (!aresetn) begin
			fault_a_r <= 1'b0;
			fault_b_r <= 1'b0;
			diode_r   <= 1'b0;
		end else begin
			fault_a_r <= fault_a_nxt;
			fault_b_r <= fault_b_nxt;
			diode_r   <= diode_nxt;
		end
	end

	assign out_a_fault_detect           = fault_a_r;
	assign out_b_fault_detect           = fault_b_r;
	assign ideal_diode_emulation_detect = diode_r;

	////////////////////////////////////////////////////////////////////////////
	// Interrupt events: a rising detection is one event
	assign ev_rise[`PFS_EV_OUT_A] = fault_a_nxt & ~fault_a_r;
	assign ev_rise[`PFS_EV_OUT_B] = fault_b_nxt & ~fault_b_r;
	assign ev_rise[`PFS_EV_DIODE] = diode_nxt & ~diode_r;

	assign live_state = {29'h0, diode_r, fault_b_r, fault_a_r};

	// Read of status clears it; an event in the same cycle wins over the clear
	always @* begin
		irq_status_nxt = irq_status_r;
		if (ar_take && (s_axi_araddr == `PFS_ADDR_IRQ_STATUS)) begin
			irq_status_nxt = {`PFS_EV_W{1'b0}};
		end
		irq_status_nxt = irq_status_nxt | ev_rise;
	end

	// Status and interrupt level
	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_status_r <= {`PFS_EV_W{1'b0}};
			irq_r        <= 1'b0;
		end else begin
			irq_status_r <= irq_status_nxt;
			irq_r        <= |(irq_status_nxt & irq_mask_r[`PFS_EV_W-1:0]);
		end
	end

	assign irq = irq_r;

	////////////////////////////////////////////////////////////////////////////
	// AXI write channel
	// Address and data are caught separately in either order; the write is
	// applied once both are held, raising the response in the same cycle. Each ready
	// stays low until the response is taken, so one write at a time.

	assign do_write = aw_full_r & w_full_r & ~bvalid_r;

	always @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			aw_full_r <= 1'b0;
			w_full_r  <= 1'b0;
			aw_addr_r <= 32'h00000000;
			w_data_r  <= 32'h00000000;
			w_strb_r  <= 4'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= `PFS_RESP_OKAY;
		end else begin
			// Catch the address
			if (s_axi_awvalid && awready_r) begin
				aw_addr_r <= s_axi_awaddr;
				aw_full_r <= 1'b1;
				awready_r <= 1'b0;
			end
			// Catch the data
			if (s_axi_wvalid && wready_r) begin
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
				w_full_r <= 1'b1;
				wready_r <= 1'b0;
			end
			// Both held: commit and answer
			if (do_write) begin
				aw_full_r <= 1'b0;
				w_full_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				if (addr_mapped(aw_addr_r)) begin
					bresp_r <= `PFS_RESP_OKAY;
				end else begin
					bresp_r <= `PFS_RESP_SLVERR;
				end
			end
			// Response taken: reopen both slots
			if (bvalid_r && s_axi_bready) begin
				bvalid_r  <= 1'b0;
				awready_r <= 1'b1;
				wready_r  <= 1'b1;
			end
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready  = wready_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;

	////////////////////////////////////////////////////////////////////////////
	// Writable registers
	// Reserved bits are masked at the write so they can never read back set.
	always @(posedge aclk) begin
		if (!aresetn) begin
			fault_en_r <= `PFS_RST_FAULT_EN;
			diode_en_r <= `PFS_RST_DIODE_EN;
			irq_mask_r <= `PFS_RST_IRQ_MASK;
		end else if (do_write) begin
			case (aw_addr_r)
				`PFS_ADDR_FAULT_EN: begin
					fault_en_r <= strobe_merge(fault_en_r, w_data_r, w_strb_r,
						`PFS_WMASK_FAULT_EN);
				end
				`PFS_ADDR_DIODE_EN: begin
					diode_en_r <= strobe_merge(diode_en_r, w_data_r, w_strb_r,
						`PFS_WMASK_DIODE_EN);
				end
				`PFS_ADDR_IRQ_MASK: begin
					irq_mask_r <= strobe_merge(irq_mask_r, w_data_r, w_strb_r,
						`PFS_WMASK_IRQ_MASK);
				end
				default: begin
					// Status and live state are read only; others unmapped
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AXI read channel
	// Data is sampled at the address handshake; the status read returns the
	// bits as they were before the clear-on-read takes effect.

	assign ar_take = s_axi_arvalid & arready_r;

	always @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h00000000;
			rresp_r   <= `PFS_RESP_OKAY;
		end else begin
			if (ar_take) begin
				arready_r <= 1'b0;
				rvalid_r  <= 1'b1;
				rresp_r   <= `PFS_RESP_OKAY;
				case (s_axi_araddr)
					`PFS_ADDR_FAULT_EN: begin
						rdata_r <= fault_en_r;
					end
					`PFS_ADDR_DIODE_EN: begin
						rdata_r <= diode_en_r;
					end
					`PFS_ADDR_IRQ_STATUS: begin
						rdata_r <= {29'h0, irq_status_r};
					end
					`PFS_ADDR_IRQ_MASK: begin
						rdata_r <= irq_mask_r;
					end
					`PFS_ADDR_LIVE_STATE: begin
						rdata_r <= live_state;
					end
					default: begin
						// Unmapped: zero data, slave error
						rdata_r <= 32'h00000000;
						rresp_r <= `PFS_RESP_SLVERR;
					end
				endcase
			end else if (rvalid_r && s_axi_rready) begin
				rvalid_r  <= 1'b0;
				arready_r <= 1'b1;
			end
		end
	end

	assign s_axi_arready = arready_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

endmodule

// ===== sim/pfs_properties.sv
// Port-level checks of the fault source selector
`timescale 1ns/100ps
`include "pfs_consts.vh"
module pfs_properties (
	input wire        aclk,
	input wire        aresetn,
	input wire        s_axi_awready,
	input wire        s_axi_wready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0]  s_axi_rresp,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [3:0]  digital_threshold_compare,
	input wire [3:0]  ext_fault_in,
	input wire [6:0]  analog_threshold_compare,
	input wire        out_a_fault_detect,
	input wire        out_b_fault_detect,
	input wire        ideal_diode_emulation_detect,
	input wire        irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////////////////////
	// Decoded read address; anything outside the map must be refused
	wire ar_map = s_axi_araddr == `PFS_ADDR_FAULT_EN || s_axi_araddr == `PFS_ADDR_DIODE_EN
		|| s_axi_araddr == `PFS_ADDR_IRQ_STATUS || s_axi_araddr == `PFS_ADDR_IRQ_MASK
		|| s_axi_araddr == `PFS_ADDR_LIVE_STATE;
	// All sources quiet for the synchroniser depth
	wire quiet = digital_threshold_compare == 4'h0 && ext_fault_in == 4'h0
		&& analog_threshold_compare == 7'h00;
	////////////////////////////////////////////////////////////////////////////////
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("Write response dropped early");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("Read data dropped early");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("Read answer late");
	a_wr_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("Write slot open while answering");
	a_rd_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("Read slot open while answering");
	a_rd_refuse: assert property (s_axi_arvalid && s_axi_arready && !ar_map |=>
		s_axi_rresp == `PFS_RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("Unmapped read not refused");
	a_reset_quiet: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid
		&& !out_a_fault_detect && !out_b_fault_detect && !ideal_diode_emulation_detect
		&& !irq) else $error("Outputs active after reset");
	a_src_quiet: assert property (quiet [*3] |=> !out_a_fault_detect
		&& !out_b_fault_detect && !ideal_diode_emulation_detect)
		else $error("Detection without any source");
	// Main scenarios reached
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_refuse: cover property (s_axi_rvalid && s_axi_rresp == `PFS_RESP_SLVERR);
	c_out_b: cover property ($rose(out_b_fault_detect));
	c_irq: cover property ($rose(irq));
endmodule

// ===== sim/pfs_tb.sv
// Self-checking bench for the fault source selector
`timescale 1ns/100ps
`include "pfs_consts.vh"
module testbench;
	reg         aclk = 1'b0;
	reg         aresetn;
	reg  [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr;
	reg  [3:0]  s_axi_wstrb, digital_threshold_compare, ext_fault_in;
	reg  [6:0]  analog_threshold_compare;
	reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0]  s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire        out_a_fault_detect, out_b_fault_detect, ideal_diode_emulation_detect, irq;
	// Scoreboard: enable registers and the applied source vector
	integer     err_count = 0, n_tests = 0, i, g, k;
	reg  [31:0] fault_m = 0, diode_m = 0, v;
	reg  [14:0] s = 0;

	pfs_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.digital_threshold_compare, .ext_fault_in, .analog_threshold_compare,
		.out_a_fault_detect, .out_b_fault_detect, .ideal_diode_emulation_detect, .irq);

	// 40 MHz clock
	always #12.5 aclk = ~aclk;
	////////////////////////////////////////////////////////////////////////////////
	task chk(input string nm, input [31:0] seen, input [31:0] exp);
		begin
			n_tests = n_tests + 1;
			if (seen !== exp) begin
				err_count = err_count + 1;
				$display("[ERR] %s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	// Expected response: five mapped words, the rest refused
	function [1:0] resp_of(input [31:0] a);
		resp_of = (a == `PFS_ADDR_FAULT_EN || a == `PFS_ADDR_DIODE_EN
			|| a == `PFS_ADDR_IRQ_STATUS || a == `PFS_ADDR_IRQ_MASK
			|| a == `PFS_ADDR_LIVE_STATE) ? `PFS_RESP_OKAY : `PFS_RESP_SLVERR;
	endfunction
	// Write: address and data offered together, each released when taken
	task wr(input [31:0] a, input [31:0] d);
		reg da, dw;
		reg [31:0] be;
		begin
			da = 0;
			dw = 0;
			// Byte lanes from the strobes in force when the task is called; a strobe set by <= just before the call is not yet seen
			be = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
				{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
			@(posedge aclk);
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			while (!(da && dw)) begin
				@(posedge aclk);
				if (s_axi_awvalid && s_axi_awready === 1'b1) begin
					s_axi_awvalid <= 1'b0;
					da = 1;
				end
				if (s_axi_wvalid && s_axi_wready === 1'b1) begin
					s_axi_wvalid <= 1'b0;
					dw = 1;
				end
			end
			do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
			s_axi_bready <= 1'b0;
			chk("bresp", s_axi_bresp, resp_of(a));
			if (a == `PFS_ADDR_FAULT_EN)
				fault_m = ((fault_m & ~be) | (d & be)) & `PFS_WMASK_FAULT_EN;
			if (a == `PFS_ADDR_DIODE_EN)
				diode_m = ((diode_m & ~be) | (d & be)) & `PFS_WMASK_DIODE_EN;
		end
	endtask
	// Read and compare the bits selected by m
	task rd(input [31:0] a, input [31:0] e, input [31:0] m);
		begin
			@(posedge aclk);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			do @(posedge aclk); while (s_axi_arready !== 1'b1);
			s_axi_arvalid <= 1'b0;
			do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
			s_axi_rready <= 1'b0;
			chk("rdata", s_axi_rdata & m, e);
			chk("rresp", s_axi_rresp, resp_of(a));
		end
	endtask
	// Apply sources, let the synchronisers settle, compare all detections
	task drive(input [14:0] x);
		begin
			s = x;
			@(posedge aclk);
			digital_threshold_compare <= x[14:11];
			ext_fault_in <= x[10:7];
			analog_threshold_compare <= x[6:0];
			repeat (4) @(posedge aclk);
			chk("out_a", out_a_fault_detect, |(fault_m[14:0] & s));
			chk("out_b", out_b_fault_detect, |(fault_m[30:16] & s));
			chk("diode", ideal_diode_emulation_detect, |(diode_m[6:0] & s[6:0]));
		end
	endtask
	task conclude;
		begin
			$display("Comparisons %0d, mismatches %0d", n_tests, err_count);
			if (err_count == 0 && n_tests > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Watchdog: far beyond the thousand or so cycles the tests need
	initial begin
		repeat (40000) @(posedge aclk);
		err_count = err_count + 1;
		conclude;
	end
	// Main sequence
	initial begin
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
		{digital_threshold_compare, ext_fault_in, analog_threshold_compare} = 0;
		s_axi_wstrb = 4'hf;
		aresetn = 1'b0;
		v = $urandom(21911);
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`PFS_ADDR_FAULT_EN, 32'h0, 32'hffffffff);
		rd(`PFS_ADDR_DIODE_EN, 32'h0, 32'hffffffff);
		drive(15'h7fff);
		$display("Test reset done");
		// All ones first, so unused bits 15 and 31 are seen to stay clear
		for (i = 0; i < 6; i = i + 1) begin
			v = i ? $urandom : 32'hffffffff;
			wr(`PFS_ADDR_FAULT_EN, v);
			wr(`PFS_ADDR_DIODE_EN, ~v);
			rd(`PFS_ADDR_FAULT_EN, v & `PFS_WMASK_FAULT_EN, 32'hffffffff);
			rd(`PFS_ADDR_DIODE_EN, ~v & `PFS_WMASK_DIODE_EN, 32'hffffffff);
		end
		// Unmapped place: refused, fault enable untouched
		wr(32'h00130050, $urandom);
		rd(32'h00130050, 32'h0, 32'hffffffff);
		rd(`PFS_ADDR_FAULT_EN, fault_m, 32'hffffffff);
		// Reset in mid-run must clear enables that were set
		wr(`PFS_ADDR_FAULT_EN, 32'hffffffff);
		wr(`PFS_ADDR_DIODE_EN, 32'hffffffff);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		fault_m = 0;
		diode_m = 0;
		rd(`PFS_ADDR_FAULT_EN, 32'h0, 32'hffffffff);
		rd(`PFS_ADDR_DIODE_EN, 32'h0, 32'hffffffff);
		drive(15'h7fff);
		// Byte lanes: only strobed bytes change, bit 15 lies outside them
		s_axi_wstrb <= 4'h5;
		wr(`PFS_ADDR_FAULT_EN, 32'hffffffff);
		s_axi_wstrb <= 4'hf;
		rd(`PFS_ADDR_FAULT_EN, 32'h00ff00ff, 32'hffffffff);
		drive(15'h7fff);
		$display("Test registers done");
		// One enable at a time: its source alone, then all the others
		for (i = 0; i < 15; i = i + 1)
			for (g = 0; g < 2; g = g + 1) begin
				wr(`PFS_ADDR_FAULT_EN, 32'h1 << (i + 16 * g));
				if (g == 0) wr(`PFS_ADDR_DIODE_EN, 32'h1 << i);
				for (k = 0; k < 2; k = k + 1)
					drive(k ? ~(15'h1 << i) : 15'h1 << i);
			end
		for (i = 0; i < 20; i = i + 1) begin
			wr(`PFS_ADDR_FAULT_EN, $urandom);
			wr(`PFS_ADDR_DIODE_EN, $urandom);
			v = $urandom;
			drive(v[14:0]);
		end
		$display("Test selection done");
		// Interrupt raised, cleared by reading, then masked
		drive(15'h0);
		wr(`PFS_ADDR_FAULT_EN, 32'h1);
		wr(`PFS_ADDR_DIODE_EN, 32'h0);
		wr(`PFS_ADDR_IRQ_MASK, 32'h7);
		rd(`PFS_ADDR_IRQ_STATUS, 32'h0, 32'h0);
		// First read cleared it: nothing left, level low
		rd(`PFS_ADDR_IRQ_STATUS, 32'h0, 32'hffffffff);
		chk("irq", irq, 0);
		drive(15'h1);
		chk("irq", irq, 1);
		rd(`PFS_ADDR_IRQ_STATUS, 32'h1, 32'hffffffff);
		repeat (2) @(posedge aclk);
		chk("irq", irq, 0);
		rd(`PFS_ADDR_LIVE_STATE, 32'h1, 32'h7);
		wr(`PFS_ADDR_IRQ_MASK, 32'h0);
		drive(15'h0);
		drive(15'h1);
		chk("irq", irq, 0);
		rd(`PFS_ADDR_IRQ_STATUS, 32'h1, 32'hffffffff);
		$display("Test interrupt done");
		conclude;
	end
endmodule

bind pfs_top pfs_properties u_props (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
	.digital_threshold_compare, .ext_fault_in, .analog_threshold_compare,
	.out_a_fault_detect, .out_b_fault_detect, .ideal_diode_emulation_detect, .irq);
